// ==== hdl/masi_top.sv ====
// Behaviour
// - Group halt line is driven low on stop and read back to halt motion.
// - No motion may start while the emergency halt input is low.
// - Emergency halt low during motion halts the axis at once.
// - Limit inputs active high when polarity select low, active low when high.
// - Active limit stops only its own direction, immediately or by ramp.
// - Slowdown causes a ramp stop, level or latched, with selectable polarity.
// - Home switch is detected on its active edge, polarity selectable.
// - Active fault input halts the axis immediately or by ramp.
// - Active edge of the position trigger starts a positioning move.
// - Servo settled input is polarity selectable and shown in extension status.
// - Active capture edge stores both position counters.
// - Encoder counts quadrature at 1x, 2x, 4x, or separate up/down pulses.
// - Quadrature counts up when phase A leads, direction reversible by software.
// - Index marker is polarity selectable, edge reported, state shown in status.
// - Handwheel counts quadrature 1x/2x/4x or plus/minus pulses, direction reversible.
// - Handwheel and jog inputs are honoured only while enable_n is low.
// - Pin 0 is general purpose I/O or accelerating flag with selectable polarity.
// - Pin 1 is general purpose I/O or decelerating flag with selectable polarity.
// - Limit, slowdown, home and fault states are readable in sub status word.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "masi_defs.svh"

module masi_top (
   // Clock, reset and clock enable.
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Register port.
   input wire logic [`MASI_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Motion core.
   input wire masi_pkg::masi_motion_t motion,
   input wire logic [31:0] counter1,
   input wire logic [31:0] counter2,
   output logic start_grant,
   output logic halt_now,
   output logic halt_ramp,
   output logic home_edge,
   output logic index_edge,
   output logic pos_start,
   output logic capture_evt,
   output logic hw_step,
   output logic hw_up,
   output logic jog_fwd,
   output logic jog_rev,
   // Shared group halt line, active low.
   input wire logic group_halt_line_i,
   output logic group_halt_line_o,
   output logic group_halt_line_oe,
   // Supervision pins.
   input wire logic emergency_halt_in,
   input wire logic limit_polarity_select,
   input wire logic fwd_limit_in,
   input wire logic rev_limit_in,
   input wire logic slowdown_in,
   input wire logic home_switch_in,
   input wire logic fault_in,
   input wire logic position_start_trigger,
   input wire logic servo_settled_in,
   input wire logic counter_capture_in,
   // Encoder and handwheel pins.
   input wire logic encoder_phase_a,
   input wire logic encoder_phase_b,
   input wire logic encoder_index_marker,
   input wire logic handwheel_phase_a,
   input wire logic handwheel_phase_b,
   input wire logic handwheel_enable_n,
   // Dual use pins.
   input wire logic gpio0_or_accel_flag_i,
   output logic gpio0_or_accel_flag_o,
   output logic gpio0_or_accel_flag_oe,
   input wire logic gpio1_or_decel_flag_i,
   output logic gpio1_or_decel_flag_o,
   output logic gpio1_or_decel_flag_oe
);

   masi_pkg::masi_state_t st_reg;
   masi_pkg::masi_state_t st_next;
   logic [`MASI_NUM_IN-1:0] pins;
   logic [`MASI_NUM_IN-1:0] inv;
   logic [`MASI_NUM_IN-1:0] act;
   logic [`MASI_NUM_IN-1:0] act_prev;
   logic [`MASI_NUM_IN-1:0] rise;
   logic [31:0] sub_status_word;
   logic [31:0] extension_status_word;
   logic [1:0] enc_q;
   logic [1:0] hw_q;
   logic hw_enabled;

   assign pins = {gpio1_or_decel_flag_i, gpio0_or_accel_flag_i, handwheel_enable_n, handwheel_phase_b,
                  handwheel_phase_a, encoder_phase_b, encoder_phase_a, encoder_index_marker,
                  counter_capture_in, servo_settled_in, position_start_trigger, fault_in,
                  home_switch_in, slowdown_in, rev_limit_in, fwd_limit_in, limit_polarity_select,
                  emergency_halt_in, group_halt_line_i};

   // A set polarity bit means active high; reset leaves the negative-logic inputs active low.
   always_comb begin
      inv = '0;
      inv[`MASI_IN_GH] = 1'b1;
      inv[`MASI_IN_EMG] = 1'b1;
      inv[`MASI_IN_FWD] = st_reg.s2[`MASI_IN_LPOL];
      inv[`MASI_IN_REV] = st_reg.s2[`MASI_IN_LPOL];
      inv[`MASI_IN_SD] = ~st_reg.cfg.sd_pol;
      inv[`MASI_IN_HOME] = ~st_reg.cfg.home_pol;
      inv[`MASI_IN_FAULT] = ~st_reg.cfg.fault_pol;
      inv[`MASI_IN_TRIG] = ~st_reg.cfg.trig_pol;
      inv[`MASI_IN_SETTLED] = ~st_reg.cfg.settled_pol;
      inv[`MASI_IN_CAPTURE] = ~st_reg.cfg.capture_pol;
      inv[`MASI_IN_INDEX] = ~st_reg.cfg.index_pol;
      inv[`MASI_IN_HEN] = 1'b1;
   end

   // only the second and third stages are read
   genvar gi;
   generate
      for (gi = 0; gi < `MASI_NUM_IN; gi++) begin : g_in
         assign act[gi] = st_reg.s2[gi] ^ inv[gi];
         assign act_prev[gi] = st_reg.s3[gi] ^ inv[gi];
         assign rise[gi] = act[gi] & ~act_prev[gi];
      end
   endgenerate

   // Returns {count enable, count up} for one sample of a two-phase input.
   function automatic logic [1:0] quad_step(input logic [1:0] mode, input logic pa, input logic pb,
                                            input logic a, input logic b);
      logic ca;
      logic cb;
      logic en;
      logic up;
      ca = a ^ pa;
      cb = b ^ pb;
      up = a ^ pb;
      case (mode)
         `MASI_MODE_1X: en = ca & ~cb & ~b;
         `MASI_MODE_2X: en = ca & ~cb;
         `MASI_MODE_4X: en = ca ^ cb;
         default: begin
            en = (a & ~pa) ^ (b & ~pb);
            up = a & ~pa;
         end
      endcase
      return {en, up};
   endfunction

   // phase A leading counts up, reversal flips it
   always_comb begin
      enc_q = quad_step(st_reg.cfg.enc_mode, st_reg.s3[`MASI_IN_EA], st_reg.s3[`MASI_IN_EB],
                        st_reg.s2[`MASI_IN_EA], st_reg.s2[`MASI_IN_EB]);
      enc_q[0] = enc_q[0] ^ st_reg.cfg.enc_rev;
      hw_q = quad_step(st_reg.cfg.hw_mode, st_reg.s3[`MASI_IN_HA], st_reg.s3[`MASI_IN_HB],
                       st_reg.s2[`MASI_IN_HA], st_reg.s2[`MASI_IN_HB]);
      hw_q[0] = hw_q[0] ^ st_reg.cfg.hw_rev;
   end

   assign hw_enabled = act[`MASI_IN_HEN];

   assign sub_status_word = {26'h0000000, st_reg.sd_latch, act[`MASI_IN_FAULT], act[`MASI_IN_HOME],
                             act[`MASI_IN_SD], act[`MASI_IN_REV], act[`MASI_IN_FWD]};
   assign extension_status_word = {23'h000000, hw_enabled, st_reg.s2[`MASI_IN_GP1], st_reg.s2[`MASI_IN_GP0],
                                   act[`MASI_IN_INDEX], act[`MASI_IN_CAPTURE], act[`MASI_IN_SETTLED],
                                   act[`MASI_IN_TRIG], act[`MASI_IN_EMG], act[`MASI_IN_GH]};

   assign start_grant = motion.start_req & ~act[`MASI_IN_EMG];

   always_comb begin
      logic lim_hit;
      logic sd_hit;
      logic wr_ctl;
      logic own_halt;
      lim_hit = 1'b0;
      sd_hit = 1'b0;
      wr_ctl = 1'b0;
      own_halt = 1'b0;
      st_next = st_reg;
      st_next.s1 = pins;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      wr_ctl = reg_wr && (reg_addr == `MASI_ADDR_CONTROL);
      if (reg_wr && (reg_addr == `MASI_ADDR_CONFIG)) begin
         st_next.cfg = reg_wdata[`MASI_CFG_W-1:0];
      end
      // latched slowdown, a new edge wins over a clear
      if (wr_ctl && reg_wdata[`MASI_CTL_SD_CLR]) begin
         st_next.sd_latch = 1'b0;
      end
      if (rise[`MASI_IN_SD] && st_reg.cfg.sd_latched) begin
         st_next.sd_latch = 1'b1;
      end
      sd_hit = st_reg.cfg.sd_latched ? st_reg.sd_latch : act[`MASI_IN_SD];
      // limit stops the matching direction only
      lim_hit = motion.moving & ((motion.dir_fwd & act[`MASI_IN_FWD]) | (~motion.dir_fwd & act[`MASI_IN_REV]));
      // emergency and group halt stop at once
      own_halt = motion.moving & (act[`MASI_IN_EMG] | (lim_hit & ~st_reg.cfg.limit_decel) |
                 (act[`MASI_IN_FAULT] & ~st_reg.cfg.fault_decel));
      st_next.halt_now = own_halt | (motion.moving & act[`MASI_IN_GH]);
      st_next.halt_ramp = motion.moving & (sd_hit | (lim_hit & st_reg.cfg.limit_decel) |
                          (act[`MASI_IN_FAULT] & st_reg.cfg.fault_decel));
      st_next.home_edge = rise[`MASI_IN_HOME];
      st_next.index_edge = rise[`MASI_IN_INDEX];
      st_next.pos_start = rise[`MASI_IN_TRIG] & ~act[`MASI_IN_EMG];
      st_next.capture_evt = rise[`MASI_IN_CAPTURE];
      if (rise[`MASI_IN_CAPTURE]) begin
         st_next.latch1 = counter1;
         st_next.latch2 = counter2;
      end
      if (wr_ctl && reg_wdata[`MASI_CTL_CNT_CLR]) begin
         st_next.enc_cnt = '0;
         st_next.hw_cnt = '0;
      end else begin
         if (enc_q[1]) begin
            st_next.enc_cnt = enc_q[0] ? st_reg.enc_cnt + 32'h00000001 : st_reg.enc_cnt - 32'h00000001;
         end
         if (hw_q[1] && hw_enabled && !st_reg.cfg.jog_mode) begin
            st_next.hw_cnt = hw_q[0] ? st_reg.hw_cnt + 32'h00000001 : st_reg.hw_cnt - 32'h00000001;
         end
      end
      st_next.hw_step = hw_q[1] & hw_enabled & ~st_reg.cfg.jog_mode;
      st_next.hw_up = hw_q[0];
      // Jog switches share the handwheel pins and are read as plain levels.
      st_next.jog_fwd = hw_enabled & st_reg.cfg.jog_mode & st_reg.s2[`MASI_IN_HA];
      st_next.jog_rev = hw_enabled & st_reg.cfg.jog_mode & st_reg.s2[`MASI_IN_HB];
      st_next.gp0_oe = st_reg.cfg.gp0_flag | st_reg.cfg.gp0_oe;
      st_next.gp0_o = st_reg.cfg.gp0_flag ? (motion.ramp_up ^ ~st_reg.cfg.accel_pol) : st_reg.cfg.gp0_out;
      st_next.gp1_oe = st_reg.cfg.gp1_flag | st_reg.cfg.gp1_oe;
      st_next.gp1_o = st_reg.cfg.gp1_flag ? (motion.ramp_down ^ ~st_reg.cfg.decel_pol) : st_reg.cfg.gp1_out;
      // pull the shared line low on a stop request, or on an own immediate halt when group_halt_drive is set
      // A halt caused by the shared line itself must not drive it, or the line would hold itself low forever.
      st_next.gh_oe = motion.stop_req | (st_reg.cfg.group_halt_drive & own_halt);
      st_next.rdata = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            `MASI_ADDR_CONFIG: st_next.rdata = {6'h00, st_reg.cfg};
            `MASI_ADDR_SUB_STATUS: st_next.rdata = sub_status_word;
            `MASI_ADDR_EXT_STATUS: st_next.rdata = extension_status_word;
            `MASI_ADDR_ENC_COUNT: st_next.rdata = st_reg.enc_cnt;
            `MASI_ADDR_HW_COUNT: st_next.rdata = st_reg.hw_cnt;
            `MASI_ADDR_LATCH1: st_next.rdata = st_reg.latch1;
            `MASI_ADDR_LATCH2: st_next.rdata = st_reg.latch2;
            default: st_next.rdata = 32'h00000000;
         endcase
      end
   end

   // Holding ce low freezes synchronisers too, so a short pin pulse during a freeze is missed.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign halt_now = st_reg.halt_now;
   assign halt_ramp = st_reg.halt_ramp;
   assign home_edge = st_reg.home_edge;
   assign index_edge = st_reg.index_edge;
   assign pos_start = st_reg.pos_start;
   assign capture_evt = st_reg.capture_evt;
   assign hw_step = st_reg.hw_step;
   assign hw_up = st_reg.hw_up;
   assign jog_fwd = st_reg.jog_fwd;
   assign jog_rev = st_reg.jog_rev;
   assign group_halt_line_o = 1'b0;
   assign group_halt_line_oe = st_reg.gh_oe;
   assign gpio0_or_accel_flag_o = st_reg.gp0_o;
   assign gpio0_or_accel_flag_oe = st_reg.gp0_oe;
   assign gpio1_or_decel_flag_o = st_reg.gp1_o;
   assign gpio1_or_decel_flag_oe = st_reg.gp1_oe;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence capture_rise_s;
      ce && rise[`MASI_IN_CAPTURE];
   endsequence

   sequence enc_idle_s;
      ce && !enc_q[1] && !(reg_wr && reg_addr == `MASI_ADDR_CONTROL);
   endsequence

   emg_start_block_a: assert property (!st_reg.s2[`MASI_IN_EMG] |-> !start_grant)
      else $error("start granted under emergency halt");

   emg_halt_a: assert property (ce && !st_reg.s2[`MASI_IN_EMG] && motion.moving |=> halt_now)
      else $error("emergency halt did not stop motion");

   group_halt_a: assert property (ce && motion.stop_req |=> group_halt_line_oe && !group_halt_line_o)
      else $error("group halt line not driven on stop");

   group_release_a: assert property (ce && !motion.stop_req && !motion.moving |=> !group_halt_line_oe)
      else $error("group halt line held while idle");

   limit_dir_a: assert property (ce && motion.moving && motion.dir_fwd && act[`MASI_IN_FWD]
                                 && !st_reg.cfg.limit_decel |=> halt_now)
      else $error("forward limit did not halt");

   sd_latch_a: assert property (ce && rise[`MASI_IN_SD] && st_reg.cfg.sd_latched |=> st_reg.sd_latch)
      else $error("slowdown edge not latched");

   home_edge_a: assert property (ce && rise[`MASI_IN_HOME] |=> home_edge ##1 (!ce || !home_edge))
      else $error("home edge pulse wrong");

   fault_halt_a: assert property (ce && motion.moving && act[`MASI_IN_FAULT]
                                  && !st_reg.cfg.fault_decel |=> halt_now)
      else $error("fault did not halt");

   trig_emg_a: assert property (ce && act[`MASI_IN_EMG] |=> !pos_start)
      else $error("positioning started under emergency halt");

   capture_vals_a: assert property (capture_rise_s |=> latch_ok(st_reg.latch1, $past(counter1)))
      else $error("counter one not captured");

   enc_hold_a: assert property (enc_idle_s |=> $stable(st_reg.enc_cnt))
      else $error("encoder count moved without a step");

   index_edge_a: assert property (ce && rise[`MASI_IN_INDEX] |=> index_edge)
      else $error("index edge not reported");

   hw_gate_a: assert property (ce && !act[`MASI_IN_HEN] |=> !hw_step && !jog_fwd && !jog_rev)
      else $error("handwheel honoured while disabled");

   accel_flag_a: assert property (ce && st_reg.cfg.gp0_flag |=> gpio0_or_accel_flag_oe)
      else $error("accel flag pin not driven");

   sync_chain_a: assert property (ce |=> st_reg.s2 == $past(st_reg.s1))
      else $error("synchroniser stage skipped");


   function automatic logic latch_ok(input logic [31:0] have, input logic [31:0] want);
      return have == want;
   endfunction

endmodule // masi_top

// ==== hdl/masi_defs.svh ====
`ifndef MASI_DEFS_SVH
`define MASI_DEFS_SVH

// Register byte addresses.
`define MASI_ADDR_W 5
`define MASI_ADDR_CONFIG 5'h00
`define MASI_ADDR_CONTROL 5'h04
`define MASI_ADDR_SUB_STATUS 5'h08
`define MASI_ADDR_EXT_STATUS 5'h0c
`define MASI_ADDR_ENC_COUNT 5'h10
`define MASI_ADDR_HW_COUNT 5'h14
`define MASI_ADDR_LATCH1 5'h18
`define MASI_ADDR_LATCH2 5'h1c

// Widths and reset values.
`define MASI_CFG_W 26
`define MASI_CFG_RESET 26'h0000000
`define MASI_CNT_W 32
`define MASI_NUM_IN 19

// Control register bits, write one to act.
`define MASI_CTL_SD_CLR 0
`define MASI_CTL_CNT_CLR 1

// Index of each pin in the synchronised input vector.
`define MASI_IN_GH 0
`define MASI_IN_EMG 1
`define MASI_IN_LPOL 2
`define MASI_IN_FWD 3
`define MASI_IN_REV 4
`define MASI_IN_SD 5
`define MASI_IN_HOME 6
`define MASI_IN_FAULT 7
`define MASI_IN_TRIG 8
`define MASI_IN_SETTLED 9
`define MASI_IN_CAPTURE 10
`define MASI_IN_INDEX 11
`define MASI_IN_EA 12
`define MASI_IN_EB 13
`define MASI_IN_HA 14
`define MASI_IN_HB 15
`define MASI_IN_HEN 16
`define MASI_IN_GP0 17
`define MASI_IN_GP1 18

// Counting modes of the encoder and handwheel inputs.
`define MASI_MODE_1X 2'h0
`define MASI_MODE_2X 2'h1
`define MASI_MODE_4X 2'h2
`define MASI_MODE_UPDN 2'h3

`endif

// ==== hdl/masi_pkg.sv ====
package masi_pkg;

   typedef struct packed {
      logic jog_mode;
      logic group_halt_drive;
      logic gp1_out;
      logic gp0_out;
      logic gp1_oe;
      logic gp0_oe;
      logic decel_pol;
      logic accel_pol;
      logic gp1_flag;
      logic gp0_flag;
      logic fault_decel;
      logic limit_decel;
      logic hw_rev;
      logic [1:0] hw_mode;
      logic enc_rev;
      logic [1:0] enc_mode;
      logic index_pol;
      logic capture_pol;
      logic settled_pol;
      logic trig_pol;
      logic fault_pol;
      logic home_pol;
      logic sd_latched;
      logic sd_pol;
   } masi_cfg_t;

   typedef struct packed {
      logic [18:0] s1;
      logic [18:0] s2;
      logic [18:0] s3;
      masi_cfg_t cfg;
      logic sd_latch;
      logic [31:0] enc_cnt;
      logic [31:0] hw_cnt;
      logic [31:0] latch1;
      logic [31:0] latch2;
      logic [31:0] rdata;
      logic halt_now;
      logic halt_ramp;
      logic home_edge;
      logic index_edge;
      logic pos_start;
      logic capture_evt;
      logic hw_step;
      logic hw_up;
      logic jog_fwd;
      logic jog_rev;
      logic gp0_o;
      logic gp0_oe;
      logic gp1_o;
      logic gp1_oe;
      logic gh_oe;
   } masi_state_t;

   // Motion core signals that this block supervises.
   typedef struct packed {
      logic start_req;
      logic moving;
      logic dir_fwd;
      logic ramp_up;
      logic ramp_down;
      logic stop_req;
   } masi_motion_t;

endpackage : masi_pkg

// ==== verif/masi_partner.sv ====
`timescale 1ns/100ps

module masi_partner (
   // Clock.
   input wire logic clk,
   // Lines driven by the block.
   input wire logic gh_o,
   input wire logic gh_oe,
   input wire logic [1:0] gp_o,
   input wire logic [1:0] gp_oe,
   // Resolved wires and switch levels.
   output logic gh_line,
   output logic [1:0] gp_line,
   output logic [15:0] pins
);
   // Bits 15:0 are switch and sensor pins, bit 16 pulls the halt line low, bits 18:17 drive the general pins high.
   logic [18:0] drv = 19'h08001;

   assign gh_line = (gh_oe ? gh_o : 1'b1) & ~drv[16];
   // An undriven general pin takes the level of its drv bit (17 or 18), so it reads low only while that bit is clear.
   assign gp_line = (gp_oe & gp_o) | (~gp_oe & drv[18:17]);
   assign pins = drv[15:0];

   // Steps are held four clocks so that every phase state survives the input synchronisers.
   task automatic quad(input int b, input bit back, input int n);
      int ph;
      for (int i = 1; i <= 4 * n; i++) begin
         ph = back ? (4 - i % 4) % 4 : i % 4;
         @(posedge clk);
         drv[b] <= (ph == 1 || ph == 2);
         drv[b + 1] <= (ph >= 2);
         repeat (3) @(posedge clk);
      end
   endtask

   task automatic pulse(input int k, input int n);
      repeat (n) begin
         @(posedge clk);
         drv[k] <= 1'b1;
         repeat (4) @(posedge clk);
         drv[k] <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
endmodule // masi_partner

// ==== verif/motion_axis_signal_inputs_tb.sv ====
`timescale 1ns/100ps
`include "masi_defs.svh"

module motion_axis_signal_inputs_tb;
   logic clk;
   logic sys_rst;
   logic [`MASI_ADDR_W-1:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   masi_pkg::masi_motion_t mo;
   masi_pkg::masi_cfg_t c;
   logic [31:0] c1;
   logic [31:0] c2;
   logic grant;
   logic halt_now;
   logic halt_ramp;
   logic jog_fwd;
   logic jog_rev;
   wire gh_o;
   wire gh_oe;
   wire gh_line;
   wire [1:0] gp_o;
   wire [1:0] gp_oe;
   wire [1:0] gp_line;
   wire [3:0] evt;
   wire [15:0] pins;
   int bad_count;
   int cmp_count;
   int epin[4] = '{5, 10, 7, 9};

   masi_top masi_top_i (
      .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motion(mo), .counter1(c1), .counter2(c2), .start_grant(grant),
      .halt_now(halt_now), .halt_ramp(halt_ramp), .home_edge(evt[0]), .index_edge(evt[1]), .pos_start(evt[2]),
      .capture_evt(evt[3]), .hw_step(), .hw_up(), .jog_fwd(jog_fwd), .jog_rev(jog_rev), .group_halt_line_i(gh_line),
      .group_halt_line_o(gh_o), .group_halt_line_oe(gh_oe), .emergency_halt_in(pins[0]),
      .limit_polarity_select(pins[1]), .fwd_limit_in(pins[2]), .rev_limit_in(pins[3]), .slowdown_in(pins[4]),
      .home_switch_in(pins[5]), .fault_in(pins[6]), .position_start_trigger(pins[7]),
      .servo_settled_in(pins[8]), .counter_capture_in(pins[9]), .encoder_index_marker(pins[10]),
      .encoder_phase_a(pins[11]), .encoder_phase_b(pins[12]), .handwheel_phase_a(pins[13]),
      .handwheel_phase_b(pins[14]), .handwheel_enable_n(pins[15]), .gpio0_or_accel_flag_i(gp_line[0]),
      .gpio0_or_accel_flag_o(gp_o[0]), .gpio0_or_accel_flag_oe(gp_oe[0]), .gpio1_or_decel_flag_i(gp_line[1]),
      .gpio1_or_decel_flag_o(gp_o[1]), .gpio1_or_decel_flag_oe(gp_oe[1])
   );

   masi_partner masi_partner_i (
      .clk(clk), .gh_o(gh_o), .gh_oe(gh_oe), .gp_o(gp_o), .gp_oe(gp_oe), .gh_line(gh_line),
      .gp_line(gp_line), .pins(pins)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      close_out();
   end

   task automatic close_out();
      $display("Mismatches %0d, comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      cmp_count++;
      if (got !== e) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
      end
   endtask

   task automatic cb(input logic got, input logic e);
      chk({31'h0, got}, {31'h0, e});
   endtask

   // Waits end on a falling edge so that every check sees settled outputs.
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask

   task automatic rc(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask

   task automatic wc();
      wr(`MASI_ADDR_CONFIG, 32'(c));
   endtask

   // The seven selectable input polarities active high, so those idle-low pins read inactive.
   task automatic base();
      c = '0;
      {c.index_pol, c.capture_pol, c.settled_pol, c.trig_pol, c.fault_pol, c.home_pol, c.sd_pol} = 7'h7f;
   endtask

   task automatic sp(input int k, input logic v);
      @(posedge clk);
      masi_partner_i.drv[k] <= v;
   endtask

   task automatic mv(input logic [5:0] v);
      @(posedge clk);
      mo <= v;
   endtask

   task automatic ecount(input int k, input int e);
      int n;
      n = 0;
      repeat (8) begin
         @(negedge clk);
         if (evt[k] === 1'b1) begin
            n++;
         end
      end
      chk(32'(n), 32'(e));
   endtask

   initial begin
      logic [31:0] r;
      logic [31:0] q;
      sys_rst = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      mo = '0;
      c = '0;
      c1 = 32'h1234_5678;
      c2 = 32'h9abc_def0;
      bad_count = 0;
      cmp_count = 0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rc(`MASI_ADDR_CONFIG, 32'h0);
      wr(`MASI_ADDR_CONFIG, 32'hffff_ffff);
      rc(`MASI_ADDR_CONFIG, 32'h03ff_ffff);
      rc(`MASI_ADDR_CONTROL, 32'h0);
      rc(5'h02, 32'h0);
      base();
      wc();
      mv(6'b110000);
      wt(6);
      cb(grant, 1'b1);
      cb(halt_now, 1'b0);
      sp(0, 1'b0);
      wt(6);
      cb(grant, 1'b0);
      cb(halt_now, 1'b1);
      sp(0, 1'b1);
      mv(6'b011000);
      sp(2, 1'b1);
      wt(6);
      cb(halt_now, 1'b1);
      rc(`MASI_ADDR_SUB_STATUS, 32'h1);
      mv(6'b010000);
      wt(4);
      cb(halt_now, 1'b0);
      c.limit_decel = 1'b1;
      wc();
      mv(6'b011000);
      wt(4);
      cb(halt_ramp, 1'b1);
      cb(halt_now, 1'b0);
      sp(1, 1'b1);
      wt(6);
      cb(halt_ramp, 1'b0);
      sp(2, 1'b0);
      wt(6);
      rc(`MASI_ADDR_SUB_STATUS, 32'h3);
      sp(1, 1'b0);
      mv(6'b010000);
      sp(3, 1'b1);
      wt(6);
      cb(halt_ramp, 1'b1);
      sp(3, 1'b0);
      base();
      wc();
      sp(6, 1'b1);
      wt(6);
      cb(halt_now, 1'b1);
      rc(`MASI_ADDR_SUB_STATUS, 32'h10);
      c.fault_decel = 1'b1;
      wc();
      wt(4);
      cb(halt_ramp, 1'b1);
      cb(halt_now, 1'b0);
      sp(6, 1'b0);
      c.fault_decel = 1'b0;
      c.group_halt_drive = 1'b1;
      wc();
      sp(16, 1'b1);
      wt(6);
      cb(halt_now, 1'b1);
      sp(16, 1'b0);
      wt(6);
      cb(halt_now, 1'b0);
      sp(6, 1'b1);
      wt(6);
      cb(gh_line, 1'b0);
      sp(6, 1'b0);
      mv(6'b000000);
      base();
      wc();
      c.sd_latched = 1'b1;
      wc();
      mv(6'b010000);
      masi_partner_i.pulse(4, 1);
      wt(6);
      rc(`MASI_ADDR_SUB_STATUS, 32'h20);
      cb(halt_ramp, 1'b1);
      wr(`MASI_ADDR_CONTROL, 32'h1);
      wt(4);
      rc(`MASI_ADDR_SUB_STATUS, 32'h0);
      cb(halt_ramp, 1'b0);
      c.sd_latched = 1'b0;
      wc();
      sp(4, 1'b1);
      sp(5, 1'b1);
      wt(6);
      rc(`MASI_ADDR_SUB_STATUS, 32'hc);
      cb(halt_ramp, 1'b1);
      sp(4, 1'b0);
      sp(5, 1'b0);
      sp(8, 1'b1);
      wt(6);
      rd(`MASI_ADDR_EXT_STATUS, r);
      sp(8, 1'b0);
      wt(6);
      rd(`MASI_ADDR_EXT_STATUS, q);
      cb(r[3] ^ q[3], 1'b1);
      {c.gp0_flag, c.gp1_flag, c.accel_pol, c.decel_pol} = 4'hf;
      wc();
      mv(6'b010100);
      wt(4);
      chk({30'h0, gp_line}, 32'h1);
      c.accel_pol = 1'b0;
      wc();
      mv(6'b010010);
      wt(4);
      chk({30'h0, gp_line}, 32'h3);
      base();
      {c.gp0_oe, c.gp0_out} = 2'h3;
      wc();
      sp(18, 1'b1);
      wt(6);
      rd(`MASI_ADDR_EXT_STATUS, r);
      chk({30'h0, r[7:6]}, 32'h3);
      c.gp0_out = 1'b0;
      wc();
      sp(18, 1'b0);
      wt(6);
      rd(`MASI_ADDR_EXT_STATUS, r);
      chk({30'h0, r[7:6]}, 32'h0);
      mv(6'b000000);
      for (int m = 0; m < 3; m++) begin
         base();
         c.enc_mode = 2'(m);
         wc();
         wr(`MASI_ADDR_CONTROL, 32'h2);
         masi_partner_i.quad(11, 1'b0, 1);
         wt(6);
         rc(`MASI_ADDR_ENC_COUNT, 32'(1 << m));
         c.enc_rev = 1'b1;
         wc();
         masi_partner_i.quad(11, 1'b0, 2);
         wt(6);
         rc(`MASI_ADDR_ENC_COUNT, 32'(-(1 << m)));
      end
      base();
      c.enc_mode = `MASI_MODE_UPDN;
      c.hw_mode = `MASI_MODE_4X;
      wc();
      wr(`MASI_ADDR_CONTROL, 32'h2);
      masi_partner_i.pulse(11, 3);
      masi_partner_i.pulse(12, 1);
      masi_partner_i.quad(13, 1'b0, 1);
      wt(6);
      rc(`MASI_ADDR_ENC_COUNT, 32'h2);
      rc(`MASI_ADDR_HW_COUNT, 32'h0);
      sp(15, 1'b0);
      masi_partner_i.quad(13, 1'b0, 1);
      wt(6);
      rc(`MASI_ADDR_HW_COUNT, 32'h4);
      masi_partner_i.quad(13, 1'b1, 2);
      wt(6);
      rc(`MASI_ADDR_HW_COUNT, 32'hffff_fffc);
      c.hw_rev = 1'b1;
      wc();
      masi_partner_i.quad(13, 1'b0, 1);
      wt(6);
      rc(`MASI_ADDR_HW_COUNT, 32'hffff_fff8);
      c.jog_mode = 1'b1;
      wc();
      sp(13, 1'b1);
      wt(6);
      cb(jog_fwd, 1'b1);
      cb(jog_rev, 1'b0);
      sp(15, 1'b1);
      wt(6);
      cb(jog_fwd, 1'b0);
      sp(13, 1'b0);
      for (int p = 1; p >= 0; p--) begin
         base();
         {c.home_pol, c.index_pol, c.trig_pol, c.capture_pol} = {4{p[0]}};
         wc();
         wt(6);
         for (int k = 0; k < 4; k++) begin
            sp(epin[k], 1'b1);
            ecount(k, p);
            sp(epin[k], 1'b0);
            ecount(k, 1 - p);
         end
      end
      rc(`MASI_ADDR_LATCH1, c1);
      rc(`MASI_ADDR_LATCH2, c2);
      close_out();
   end
endmodule // motion_axis_signal_inputs_tb
